// file: modulator_model.sv
// modulator stand-in: random one-bit stream, prompt or stalling
`timescale 1ns/10ps
`default_nettype none
module modulator_model (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // stall request from the bench
  input wire logic slow,
  // constant-one stream request from the bench
  input wire logic ones,
  // bitstream
  output var logic mod_valid,
  output var logic mod_bit
);
  initial begin
    mod_valid = 1'b0;
    mod_bit = 1'b0;
  end
  // a bit each cycle, or about every other cycle when slow
  always @(posedge mclk) begin
    mod_valid <= nrst && (!slow || $urandom_range(1));
    mod_bit <= ones || $urandom_range(1);
  end
endmodule
`default_nettype wire

// file: sdadc_regs.vh
// register map, field positions, modes and reset values of the delta-sigma sequencer
`ifndef SDADC_REGS_VH
`define SDADC_REGS_VH
// register byte offsets
`define OFS_CTRL 5'h00
`define OFS_STATUS 5'h04
`define OFS_RESULT 5'h08
`define OFS_IRQ_STAT 5'h0c
`define OFS_IRQ_MASK 5'h10
`define OFS_RATIO 5'h14
// control fields
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 3
`define CTRL_RES_LO 4
`define CTRL_RES_HI 5
`define CTRL_SHIFT_LO 8
`define CTRL_SHIFT_HI 13
// status fields
`define STAT_DONE 0
`define STAT_BUSY 1
`define STAT_VALID 2
// interrupt fields
`define IRQ_EOC 0
`define IRQ_OVR 1
// modes
`define MODE_SINGLE 2'h0
`define MODE_CONT 2'h1
`define MODE_MULTI 2'h2
`define MODE_TURBO 2'h3
// resolutions
`define RES_8 2'h0
`define RES_12 2'h1
`define RES_16 2'h2
`define RES_20 2'h3
// result masks per resolution
`define MASK_8 20'h000ff
`define MASK_12 20'h00fff
`define MASK_16 20'h0ffff
`define MASK_20 20'hfffff
// decimator outputs that only prime the pipeline
`define PRIME_CONV 2'h3
// reset values
`define MODE_RST 2'h0
`define RES_RST 2'h0
`define SHIFT_RST 6'h00
`define MASK_RST 2'h0
`define RATIO_RST 12'h040
`endif

// file: sigma_delta_adc_sequencer.v
// delta-sigma converter sequencer with decimator and avalon register slave
`timescale 1ns/10ps
`default_nettype none
`include "sdadc_regs.vh"
module sigma_delta_adc_sequencer #(
  parameter ACC_W = 49,
  parameter RW = 12
) (
  // clock, reset, enable
  input wire mclk,
  input wire nrst,
  input wire ce,
  // avalon-mm slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // modulator side
  input wire mod_valid,
  input wire mod_bit,
  output reg mod_rst,
  // hardware start and input selection change
  input wire soc_in,
  input wire sel_changed,
  // completion and interrupt
  output wire eoc_out,
  output wire irq
);
  // sequencer states
  localparam [1:0] ST_IDLE = 2'h0; // standby
  localparam [1:0] ST_CONV = 2'h1; // converting
  localparam [1:0] ST_HOLD = 2'h2; // single result waiting for read

  reg [1:0] state_q; // sequencer state
  reg [1:0] pcnt_q; // decimator outputs since last clear
  reg [1:0] mode_q; // conversion mode
  reg [1:0] res_q; // resolution select
  reg [5:0] shift_q; // result alignment shift
  reg [RW-1:0] ratio_q; // decimation ratio
  reg [19:0] result_q; // last published result
  reg done_q; // completion status
  reg [1:0] istat_q; // sticky interrupt status
  reg [1:0] imask_q; // interrupt mask
  reg soc_q; // previous start input
  reg ack_q; // bus answer phase
  reg clr_q; // decimator clear request
  reg start_req; // start bit written this access
  reg stop_req; // stop bit written this access

  wire dec_valid; // decimator word ready
  wire [ACC_W-1:0] dec_data; // decimator word
  wire [31:0] bmask; // byte-lane mask of the write
  wire wr_acc = avs_write & ack_q & ce; // write accepted this edge
  wire rd_acc = avs_read & ack_q & ce; // read accepted this edge
  wire soc_rise = soc_in & ~soc_q; // hardware start edge
  wire rd_result = rd_acc & (avs_address == `OFS_RESULT);
  wire trigger = soc_rise | start_req; // one trigger per event
  wire busy = (state_q != ST_IDLE);
  wire primed = (pcnt_q == `PRIME_CONV); // pipeline holds four samples
  wire publish = (state_q == ST_CONV) & dec_valid & primed & ~sel_changed;
  wire [ACC_W-1:0] shifted = dec_data >> shift_q;
  reg [19:0] res_mask; // result bits kept for the resolution
  reg [31:0] rdata_d; // read mux

  // byte lanes of a write
  assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // first cycle of a request waits, second cycle answers
  // a frozen clock enable keeps the master waiting, so no access is lost
  assign avs_waitrequest = (avs_read | avs_write) & ~(ack_q & ce);

  // completion output and interrupt level
  assign eoc_out = done_q;
  assign irq = |(istat_q & imask_q);

  // decode start and stop bits from an accepted control write
  always @* begin
    start_req = 1'b0;
    stop_req = 1'b0;
    if (wr_acc && avs_address == `OFS_CTRL && avs_byteenable[0]) begin
      start_req = avs_writedata[`CTRL_START];
      stop_req = avs_writedata[`CTRL_STOP];
    end
  end

  // result width per resolution
  always @* begin
    case (res_q)
      `RES_8: res_mask = `MASK_8;
      `RES_12: res_mask = `MASK_12;
      `RES_16: res_mask = `MASK_16;
      default: res_mask = `MASK_20;
    endcase
  end

  // register read mux, unmapped reads as zero
  always @* begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      `OFS_CTRL: begin
        rdata_d[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode_q;
        rdata_d[`CTRL_RES_HI:`CTRL_RES_LO] = res_q;
        rdata_d[`CTRL_SHIFT_HI:`CTRL_SHIFT_LO] = shift_q;
      end
      `OFS_STATUS: begin
        rdata_d[`STAT_DONE] = done_q;
        rdata_d[`STAT_BUSY] = busy;
        rdata_d[`STAT_VALID] = primed;
      end
      `OFS_RESULT: rdata_d[19:0] = result_q;
      `OFS_IRQ_STAT: rdata_d[1:0] = istat_q;
      `OFS_IRQ_MASK: rdata_d[1:0] = imask_q;
      `OFS_RATIO: rdata_d[RW-1:0] = ratio_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // bus answer phase and registered read data
  always @(posedge mclk) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (ce) begin
      // answer one cycle after the request, then drop
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read && !ack_q) begin
        avs_readdata <= rdata_d;
      end
    end
  end

  // software-written configuration
  always @(posedge mclk) begin
    if (!nrst) begin
      mode_q <= `MODE_RST;
      res_q <= `RES_RST;
      shift_q <= `SHIFT_RST;
      imask_q <= `MASK_RST;
      ratio_q <= `RATIO_RST;
    end else if (wr_acc) begin
      case (avs_address)
        `OFS_CTRL: begin
          // mode and resolution sit in lane 0, shift in lane 1
          if (avs_byteenable[0]) begin
            mode_q <= avs_writedata[`CTRL_MODE_HI:`CTRL_MODE_LO];
            res_q <= avs_writedata[`CTRL_RES_HI:`CTRL_RES_LO];
          end
          if (avs_byteenable[1]) begin
            shift_q <= avs_writedata[`CTRL_SHIFT_HI:`CTRL_SHIFT_LO];
          end
        end
        `OFS_IRQ_MASK: begin
          if (avs_byteenable[0]) begin
            imask_q <= avs_writedata[1:0];
          end
        end
        `OFS_RATIO: begin
          // keep lanes that are not enabled
          ratio_q <= (ratio_q & ~bmask[RW-1:0]) | (avs_writedata[RW-1:0] & bmask[RW-1:0]);
        end
        default: begin
          // other offsets hold no writable configuration
        end
      endcase
    end
  end

  // previous start input for edge detection
  always @(posedge mclk) begin
    if (!nrst) begin
      soc_q <= 1'b0;
    end else if (ce) begin
      soc_q <= soc_in;
    end
  end

  // conversion sequencer
  always @(posedge mclk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      pcnt_q <= 2'h0;
      clr_q <= 1'b1;
      mod_rst <= 1'b1;
      result_q <= 20'h00000;
    end else if (ce) begin
      clr_q <= 1'b0;
      mod_rst <= 1'b0;
      // a new selection restarts the four-sample validity count
      if (sel_changed && state_q == ST_CONV) begin
        pcnt_q <= 2'h0;
      end else if (state_q == ST_CONV && dec_valid && !primed) begin
        pcnt_q <= pcnt_q + 2'h1;
      end
      if (publish) begin
        result_q <= shifted[19:0] & res_mask;
      end
      case (state_q)
        ST_IDLE: begin
          // standby, a trigger clears converter and decimator
          if (trigger) begin
            state_q <= ST_CONV;
            pcnt_q <= 2'h0;
            clr_q <= 1'b1;
            mod_rst <= 1'b1;
          end
        end
        ST_CONV: begin
          // triggers are ignored here, stop or a single-mode result leaves
          if (stop_req) begin
            state_q <= ST_IDLE;
          end else if (publish) begin
            case (mode_q)
              `MODE_SINGLE: begin
                state_q <= ST_HOLD;
              end
              `MODE_CONT: begin
                // keep pipeline, next word is a result again
                state_q <= ST_CONV;
              end
              `MODE_MULTI: begin
                pcnt_q <= 2'h0;
                clr_q <= 1'b1;
                mod_rst <= 1'b1;
              end
              default: begin
                // turbo: full re-prime below 17 bits, else one reset per result
                pcnt_q <= (res_q == `RES_20) ? `PRIME_CONV : 2'h0;
                clr_q <= 1'b1;
                mod_rst <= 1'b1;
              end
            endcase
          end
        end
        ST_HOLD: begin
          // single result waits for transfer, then standby
          if (rd_result || !done_q || stop_req) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // completion flag, cleared by the result read, set wins
  always @(posedge mclk) begin
    if (!nrst) begin
      done_q <= 1'b0;
    end else if (ce) begin
      if (publish) begin
        done_q <= 1'b1;
      end else if (rd_result) begin
        done_q <= 1'b0;
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always @(posedge mclk) begin
    if (!nrst) begin
      istat_q <= 2'h0;
    end else if (ce) begin
      if (wr_acc && avs_address == `OFS_IRQ_STAT && avs_byteenable[0]) begin
        istat_q <= istat_q & ~avs_writedata[1:0];
      end
      if (publish) begin
        istat_q[`IRQ_EOC] <= 1'b1;
        // new result while previous still unread
        if (done_q && !rd_result) begin
          istat_q[`IRQ_OVR] <= 1'b1;
        end
      end
    end
  end

  // decimation filter on the modulator bitstream
  sinc4_decimator #(
    .ACC_W(ACC_W),
    .RW(RW)
  ) u_dec (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .clr(clr_q),
    .in_valid(mod_valid & (state_q != ST_IDLE)),
    .in_bit(mod_bit),
    .ratio(ratio_q),
    .out_valid(dec_valid),
    .out_data(dec_data)
  );
endmodule
`default_nettype wire

// file: sigma_delta_adc_sequencer_bench.sv
// self-checking bench for the delta-sigma sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sdadc_regs.vh"
module sigma_delta_adc_sequencer_bench;
  localparam int RATIO = 16; // bits per decimator word
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mod_valid;
  logic mod_bit;
  logic mod_rst;
  logic soc_in = 1'b0;
  logic sel_changed = 1'b0;
  logic slow = 1'b0;
  logic ones = 1'b0;
  logic eoc_out;
  logic irq;
  int mismatches = 0;
  int check_count = 0;
  int clears = 0; // converter clear pulses seen
  int n;
  int c0;
  logic [31:0] q;
  logic [31:0] d;
  // steady-mode runs; the last changes selection, never in continuous mode
  logic [1:0] tm [6] = '{`MODE_CONT, `MODE_MULTI, `MODE_TURBO, `MODE_TURBO, `MODE_TURBO, `MODE_TURBO};
  logic [1:0] tr [6] = '{`RES_16, `RES_12, `RES_8, `RES_16, `RES_20, `RES_20};
  sigma_delta_adc_sequencer #(.ACC_W(49), .RW(12)) sigma_delta_adc_sequencer_inst (
    .mclk(mclk), .nrst(nrst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mod_valid(mod_valid),
    .mod_bit(mod_bit), .mod_rst(mod_rst), .soc_in(soc_in), .sel_changed(sel_changed),
    .eoc_out(eoc_out), .irq(irq));
  modulator_model modulator_model_inst (.mclk(mclk), .nrst(nrst), .slow(slow), .ones(ones),
    .mod_valid(mod_valid), .mod_bit(mod_bit));
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) if (mod_rst === 1'b1) clears <= clears + 1;
  // model: a fresh priming run comes before the next result
  function automatic logic reprime(input int i);
    return i == 5 || tm[i] == `MODE_MULTI || (tm[i] == `MODE_TURBO && tr[i] != `RES_20);
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    conclude();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) hang();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_eoc(output int k);
    k = 0;
    while (eoc_out !== 1'b1) begin
      @(posedge mclk);
      k++;
      if (k > 900) hang();
    end
  endtask
  initial begin
    void'($urandom(32'hfb8d));
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(0, 5'(4 * i), 0);
      chk("reset value", i == 5 ? 32'h40 : 32'h0, q);
    end
    bus(1, `OFS_STATUS, 32'hffff);
    bus(1, 5'h18, 32'hffff);
    bus(0, `OFS_STATUS, 0);
    chk("status read-only", 0, q);
    d = $urandom;
    bus(1, `OFS_IRQ_MASK, d);
    bus(0, `OFS_IRQ_MASK, 0);
    chk("mask", d & 32'h3, q);
    bus(1, `OFS_IRQ_MASK, 1);
    bus(1, `OFS_RATIO, RATIO);
    c0 = clears;
    bus(1, `OFS_CTRL, 1);
    soc_in <= 1'b1; // edge while busy is ignored
    wait_eoc(n);
    chk("priming", 1, n >= 4 * RATIO);
    bus(0, `OFS_STATUS, 0);
    chk("done poll", 1, q[0]);
    chk("irq", 1, irq);
    bus(0, `OFS_RESULT, 0);
    soc_in <= 1'b0;
    repeat (100) @(posedge mclk);
    chk("standby", 0, eoc_out);
    chk("clears", 1, clears - c0);
    bus(1, `OFS_IRQ_STAT, 3);
    bus(0, `OFS_IRQ_STAT, 0);
    chk("irq status cleared", 0, q);
    chk("irq low", 0, irq);
    slow <= 1'b1;
    bus(1, `OFS_IRQ_MASK, 0);
    soc_in <= 1'b1;
    wait_eoc(n);
    bus(0, `OFS_IRQ_STAT, 0);
    chk("eoc event", 1, q[0]);
    chk("masked irq", 0, irq);
    bus(0, `OFS_RESULT, 0);
    chk("8-bit width", 0, q >> 8);
    ones <= 1'b1; // constant input: the fourth word carries the full sinc4 gain
    bus(1, `OFS_CTRL, {18'h0, 6'h04, 2'b00, `RES_20, `MODE_SINGLE, 2'b01});
    wait_eoc(n);
    bus(0, `OFS_RESULT, 0);
    chk("sinc4 gain", (RATIO * RATIO * RATIO * RATIO) >> 4, q);
    ones <= 1'b0;
    slow <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1, `OFS_CTRL, {26'h0, tr[i], tm[i], 2'b01});
      wait_eoc(n);
      c0 = clears;
      bus(0, `OFS_RESULT, 0);
      chk("width", 0, q >> (8 + 4 * tr[i]));
      if (i == 5) sel_changed <= 1'b1;
      @(posedge mclk);
      sel_changed <= 1'b0;
      wait_eoc(n);
      repeat (3) @(posedge mclk);
      chk("reprime gap", reprime(i), n > 2 * RATIO);
      if (i != 5) chk("clears", tm[i] != `MODE_CONT, clears != c0);
      bus(1, `OFS_CTRL, 2);
      bus(0, `OFS_RESULT, 0);
    end
    // continuous run: status bits, overrun and clock-enable freeze
    bus(1, `OFS_IRQ_STAT, 3);
    bus(1, `OFS_CTRL, {26'h0, `RES_8, `MODE_CONT, 2'b01});
    wait_eoc(n);
    bus(0, `OFS_STATUS, 0);
    chk("status bits", 7, q[2:0]);
    repeat (2 * RATIO) @(posedge mclk);
    bus(0, `OFS_IRQ_STAT, 0);
    chk("overrun", 3, q[1:0]);
    bus(0, `OFS_RESULT, 0);
    ce <= 1'b0;
    repeat (4 * RATIO) @(posedge mclk);
    chk("frozen", 0, eoc_out);
    ce <= 1'b1;
    wait_eoc(n);
    chk("resume", 1, n <= RATIO);
    bus(1, `OFS_CTRL, 2);
    bus(0, `OFS_RESULT, 0);
    conclude();
  end
endmodule
`default_nettype wire

// file: sigma_delta_adc_sequencer_properties.sv
// port-level assertion checker for the delta-sigma sequencer
`timescale 1ns/10ps
`default_nettype none
module sdadc_checker #(
  parameter ACC_W = 49,
  parameter RW = 12
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // converter side
  input wire logic mod_rst,
  input wire logic eoc_out,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst || !ce);
  // read accepted in this cycle
  wire rd_ok = avs_read && !avs_waitrequest;
  // request that was idle the cycle before
  sequence req_new;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  // one stall cycle, then acceptance
  sequence one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_bus_wait_once: assert property (req_new |-> one_wait)
    else $error("bus answer not after one wait cycle");
  a_eoc_holds: assert property (eoc_out && !(rd_ok && avs_address == 5'h08) |=> eoc_out)
    else $error("completion dropped before result read");
  a_read_clears: assert property (rd_ok && avs_address == 5'h08 |=> !eoc_out)
    else $error("completion survived result read");
  a_status_poll: assert property (rd_ok && avs_address == 5'h04 |-> avs_readdata[0] == $past(eoc_out))
    else $error("polled done bit differs from completion output");
  a_start_reads_zero: assert property (rd_ok && avs_address == 5'h00 |-> !avs_readdata[0])
    else $error("start bit did not clear itself");
  a_unmapped_zero: assert property (rd_ok && avs_address >= 5'h18 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_clear_pulse: assert property (mod_rst |=> !mod_rst)
    else $error("converter clear longer than one cycle");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> mod_rst && !eoc_out && !irq)
    else $error("outputs wrong during reset");
endmodule
bind sigma_delta_adc_sequencer sdadc_checker #(.ACC_W(ACC_W), .RW(RW)) sdadc_checker_inst (
  .mclk(mclk), .nrst(nrst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .mod_rst(mod_rst), .eoc_out(eoc_out), .irq(irq));
`default_nettype wire

// file: sinc4_decimator.v
// fourth-order sinc decimator turning the modulator bitstream into words
`timescale 1ns/10ps
`default_nettype none
module sinc4_decimator #(
  parameter ACC_W = 49,
  parameter RW = 12
) (
  // clock, reset, enable
  input wire mclk,
  input wire nrst,
  input wire ce,
  // pipeline clear
  input wire clr,
  // oversampled bitstream
  input wire in_valid,
  input wire in_bit,
  // decimation ratio
  input wire [RW-1:0] ratio,
  // parallel output
  output reg out_valid,
  output reg [ACC_W-1:0] out_data
);
  wire [ACC_W-1:0] istage [0:4]; // integrator chain
  wire [ACC_W-1:0] cstage [0:4]; // comb chain
  reg [RW-1:0] cnt_q; // input bits in this output period
  wire [RW:0] cnt_p1 = {1'b0, cnt_q} + {{RW{1'b0}}, 1'b1};
  wire tick = ce & in_valid & (cnt_p1 >= {1'b0, ratio}); // last bit of period
  assign istage[0] = {{(ACC_W-1){1'b0}}, in_bit};
  assign cstage[0] = istage[4];
  genvar i;
  // four integrators and four combs give the sinc^4 response
  generate
    for (i = 1; i <= 4; i = i + 1) begin : stg
      reg [ACC_W-1:0] acc_q; // integrator
      reg [ACC_W-1:0] dly_q; // comb delay
      // running sum including the current bit, so the fourth word after a clear is settled
      assign istage[i] = acc_q + istage[i-1];
      assign cstage[i] = cstage[i-1] - dly_q;
      always @(posedge mclk) begin
        if (!nrst || (ce && clr)) begin
          acc_q <= {ACC_W{1'b0}};
          dly_q <= {ACC_W{1'b0}};
        end else if (ce && in_valid) begin
          acc_q <= istage[i];
          if (tick) begin
            dly_q <= cstage[i-1];
          end
        end
      end
    end
  endgenerate
  // period counter and output register
  always @(posedge mclk) begin
    if (!nrst || (ce && clr)) begin
      cnt_q <= {RW{1'b0}};
      out_valid <= 1'b0;
      out_data <= {ACC_W{1'b0}};
    end else if (ce) begin
      out_valid <= tick;
      if (in_valid) begin
        cnt_q <= tick ? {RW{1'b0}} : cnt_p1[RW-1:0];
      end
      if (tick) begin
        out_data <= cstage[4];
      end
    end
  end
endmodule
`default_nettype wire
